// ===== logic/ria_alias_remap.sv
// Operation
// R01: each port owns its alias copy; port-select register steers register access
// R02: alias is a 7-bit address in bits 7:1, matched against incoming target
// R03: matched target address replaced by same-index physical id before forwarding
// R04: alias value zero disables its slot; never matches or forwards
// R05: slot auto-ack bit 0 acknowledges writes regardless of link or remote ack
// R06: eight slots per port at consecutive byte addresses, paired by index
// R07: alias and auto-ack fields are read/write and reset to zero
// R08: physical id is 7 bits in 7:1; remapped transaction sent over control channel
// R09: several matching slots resolve to the lowest-numbered one
`timescale 1ns/1ps
module ria_alias_remap (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic                     clk_en,
  input  wire ria_pkg::ria_reg_req_type reg_req,
  output logic [7:0]                    reg_rdata,
  output logic                          reg_rvalid,
  input  wire ria_pkg::ria_txn_type     txn_in,
  output ria_pkg::ria_fwd_type          fwd_out,
  output logic                          fwd_auto_ack_wr
);
  localparam int NP = ria_pkg::NUM_PORTS;
  localparam int NS = ria_pkg::NUM_SLOTS;

  logic [7:0] port_sel_r;
  logic [7:0] alias_r [NP][NS];
  logic [7:0] phys_r  [NP][NS];
  logic [1:0] acc_port;
  logic [7:0] rd_nxt;
  logic [NS-1:0] match;
  logic       hit;
  logic [2:0] hit_slot;
  logic [7:0] alias_sel;
  logic [7:0] phys_sel;
  ria_pkg::ria_fwd_type fwd_nxt;

  // port currently open to register access
  assign acc_port = port_sel_r[1:0]; // [R01]

  // port select register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_sel_r <= ria_pkg::PORT_SEL_RST;
    end else if (clk_en && reg_req.wr && reg_req.addr == ria_pkg::PORT_SEL_OFS) begin
      port_sel_r <= reg_req.wdata;
    end
  end

  // per-port, per-slot storage
  for (genvar p = 0; p < NP; p++) begin : g_port
    for (genvar s = 0; s < NS; s++) begin : g_slot
      logic wr_alias;
      logic wr_phys;
      assign wr_alias = clk_en && reg_req.wr && acc_port == 2'(p)
                        && reg_req.addr == ria_pkg::ALIAS_BASE + 8'(s); // [R01] [R06]
      assign wr_phys  = clk_en && reg_req.wr && acc_port == 2'(p)
                        && reg_req.addr == ria_pkg::PHYS_ID_BASE + 8'(s);
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          alias_r[p][s] <= ria_pkg::ALIAS_RST; // [R07]
        end else if (wr_alias) begin
          alias_r[p][s] <= reg_req.wdata; // [R07]
        end
      end
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          phys_r[p][s] <= ria_pkg::PHYS_RST;
        end else if (wr_phys) begin
          phys_r[p][s] <= {reg_req.wdata[7:1], 1'b0}; // [R08]
        end
      end
    end
  end

  // read decode
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_req.addr == ria_pkg::PORT_SEL_OFS) begin
      rd_nxt = port_sel_r;
    end else if (reg_req.addr >= ria_pkg::ALIAS_BASE
                 && reg_req.addr < ria_pkg::ALIAS_BASE + 8'(NS)) begin
      rd_nxt = alias_r[acc_port][3'(reg_req.addr - ria_pkg::ALIAS_BASE)]; // [R01]
    end else if (reg_req.addr >= ria_pkg::PHYS_ID_BASE
                 && reg_req.addr < ria_pkg::PHYS_ID_BASE + 8'(NS)) begin
      rd_nxt = phys_r[acc_port][3'(reg_req.addr - ria_pkg::PHYS_ID_BASE)];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_req.rd;
      reg_rdata  <= reg_req.rd ? rd_nxt : 8'h00;
    end
  end

  // alias compare against the transaction's port
  for (genvar s = 0; s < NS; s++) begin : g_match
    assign match[s] = alias_r[txn_in.port][s][ria_pkg::ADDR_MSB:ria_pkg::ADDR_LSB]
                      != ria_pkg::ALIAS_OFF // [R04]
                      && alias_r[txn_in.port][s][ria_pkg::ADDR_MSB:ria_pkg::ADDR_LSB]
                      == txn_in.addr; // [R02]
  end

  // lowest-numbered match wins
  always_comb begin
    hit_slot = 3'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_slot = 3'(i); // [R09]
      end
    end
  end

  assign hit       = txn_in.valid && (|match);
  assign alias_sel = alias_r[txn_in.port][hit_slot];
  assign phys_sel  = phys_r[txn_in.port][hit_slot]; // [R06]

  // forward record
  always_comb begin
    fwd_nxt           = '0;
    fwd_nxt.valid     = txn_in.valid;
    fwd_nxt.hit       = hit;
    fwd_nxt.port      = txn_in.port;
    fwd_nxt.slot      = hit ? hit_slot : 3'h0;
    fwd_nxt.phys_addr = hit ? phys_sel[ria_pkg::ADDR_MSB:ria_pkg::ADDR_LSB]
                            : 7'h00; // [R03] [R08]
    fwd_nxt.auto_ack  = hit && alias_sel[ria_pkg::AUTO_ACK_BIT]; // [R05]
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_out         <= '0;
      fwd_auto_ack_wr <= 1'b0;
    end else if (clk_en) begin
      fwd_out         <= fwd_nxt;
      fwd_auto_ack_wr <= fwd_nxt.auto_ack && txn_in.is_write; // [R05]
    end
  end

  // two-step register access: write, then read of the same byte
  sequence s_alias4_wr;
    clk_en && reg_req.wr && !reg_req.rd && reg_req.addr == ria_pkg::ALIAS_SLOT_FOUR;
  endsequence
  sequence s_alias4_rd;
    clk_en && reg_req.rd && !reg_req.wr && reg_req.addr == ria_pkg::ALIAS_SLOT_FOUR;
  endsequence
  sequence s_phys0_wr;
    clk_en && reg_req.wr && !reg_req.rd && reg_req.addr == ria_pkg::PHYS_ID_BASE;
  endsequence
  sequence s_phys0_rd;
    clk_en && reg_req.rd && !reg_req.wr && reg_req.addr == ria_pkg::PHYS_ID_BASE;
  endsequence

  // forwarding checks
  a_zero_alias_blocks: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R04]
    clk_en && txn_in.valid && txn_in.addr == 7'h00 |=> !fwd_out.hit)
    else $error("zero alias matched");
  a_remap_addr: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R03]
    clk_en && hit |=> fwd_out.phys_addr == $past(phys_sel[7:1]))
    else $error("remap address wrong");
  a_hit_matches: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R02]
    clk_en && hit |=> fwd_out.valid && fwd_out.hit && fwd_out.port == $past(txn_in.port))
    else $error("hit not forwarded");
  a_lowest_slot: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R09]
    hit |-> (match & ((8'h01 << hit_slot) - 8'h01)) == 8'h00)
    else $error("not lowest slot");
  a_slot_pair: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R06]
    clk_en && hit |=> fwd_out.slot == $past(hit_slot))
    else $error("slot pairing wrong");
  a_miss_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R04]
    clk_en && txn_in.valid && !hit
    |=> !fwd_out.hit && fwd_out.phys_addr == 7'h00 && !fwd_out.auto_ack)
    else $error("miss not cleared");
  a_idle_fwd: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R03]
    clk_en && !txn_in.valid
    |=> !fwd_out.valid && !fwd_out.hit && !fwd_auto_ack_wr)
    else $error("idle cycle forwarded");

  // auto-acknowledge checks
  a_auto_ack_wr: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R05]
    clk_en && hit && txn_in.is_write && alias_sel[0] |=> fwd_auto_ack_wr)
    else $error("auto ack missing");
  a_no_auto_ack: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R05]
    clk_en && !(hit && alias_sel[0]) |=> !fwd_auto_ack_wr)
    else $error("spurious auto ack");
  a_ack_rd_none: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R05]
    clk_en && !txn_in.is_write |=> !fwd_auto_ack_wr)
    else $error("auto ack on read");

  // register access checks
  a_alias_rdback: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R07]
    s_alias4_wr ##1 s_alias4_rd |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2))
    else $error("alias readback wrong");
  a_phys_rdback: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R08]
    s_phys0_wr ##1 s_phys0_rd
    |=> reg_rvalid && reg_rdata == {$past(reg_req.wdata[7:1], 2), 1'b0})
    else $error("physical id readback wrong");
  a_port_steer: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R01]
    clk_en && reg_req.rd && reg_req.addr == ria_pkg::ALIAS_SLOT_FIVE
    |=> reg_rdata == $past(alias_r[acc_port][5]))
    else $error("port steering wrong");
  a_alias_land: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R01]
    clk_en && reg_req.wr && acc_port == 2'h1 && reg_req.addr == ria_pkg::ALIAS_SLOT_SIX
    |=> alias_r[1][6] == $past(reg_req.wdata))
    else $error("alias write missed its port");
  a_port_sel_rd: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R01]
    clk_en && reg_req.rd && reg_req.addr == ria_pkg::PORT_SEL_OFS
    |=> reg_rdata == $past(port_sel_r))
    else $error("port select readback wrong");
  a_rvalid_follow: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R07]
    clk_en |=> reg_rvalid == $past(reg_req.rd))
    else $error("read valid wrong");
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R07]
    clk_en && !reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");

  // clock enable low holds state
  a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R07]
    !clk_en
    |=> $stable(port_sel_r) && $stable(reg_rdata) && $stable(fwd_out))
    else $error("state moved while frozen");
endmodule

// ===== logic/ria_pkg.sv
package ria_pkg;
  // geometry
  localparam int          NUM_PORTS   = 4;
  localparam int          NUM_SLOTS   = 8;
  // register map: port select, physical ids, alias slots
  localparam logic [7:0]  PORT_SEL_OFS   = 8'h4c;
  localparam logic [7:0]  PHYS_ID_BASE   = 8'h5d;
  localparam logic [7:0]  ALIAS_BASE     = 8'h65;
  localparam logic [7:0]  ALIAS_SLOT_FOUR  = 8'h69;
  localparam logic [7:0]  ALIAS_SLOT_FIVE  = 8'h6a;
  localparam logic [7:0]  ALIAS_SLOT_SIX   = 8'h6b;
  // field layout and reset values
  localparam int          ADDR_MSB    = 7;
  localparam int          ADDR_LSB    = 1;
  localparam int          AUTO_ACK_BIT = 0;
  localparam logic [7:0]  ALIAS_RST   = 8'h00;
  localparam logic [7:0]  PHYS_RST    = 8'h00;
  localparam logic [7:0]  PORT_SEL_RST = 8'h00;
  localparam logic [6:0]  ALIAS_OFF   = 7'h00;

  // register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ria_reg_req_type;

  // transaction presented for decoding
  typedef struct packed {
    logic       valid;
    logic [1:0] port;
    logic [6:0] addr;
    logic       is_write;
  } ria_txn_type;

  // result of decoding
  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [1:0] port;
    logic [2:0] slot;
    logic [6:0] phys_addr;
    logic       auto_ack;
  } ria_fwd_type;
endpackage

// ===== testbench/ria_host_model.sv
`timescale 1ns/1ps
// local bus host: offers one transaction per call
module ria_host_model (
  input  wire logic           sys_clk,
  output ria_pkg::ria_txn_type txn
);
  initial txn = '0;
  // request held one full cycle, launched at falling edge
  task automatic send(input logic [1:0] p, input logic [6:0] a, input logic w);
    @(negedge sys_clk);
    txn <= '{1'b1, p, a, w};
    @(negedge sys_clk);
    txn <= '0;
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic                     sys_clk, arst_n, clk_en;
  logic [7:0]               reg_rdata;
  logic                     reg_rvalid, fwd_auto_ack_wr;
  ria_pkg::ria_reg_req_type reg_req;
  ria_pkg::ria_txn_type     txn_in;
  ria_pkg::ria_fwd_type     fwd_out;
  int                       error_cnt, check_count, cyc;
  ria_alias_remap ria_alias_remap_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .txn_in(txn_in),
    .fwd_out(fwd_out), .fwd_auto_ack_wr(fwd_auto_ack_wr));
  ria_host_model ria_host_model_inst (.sys_clk(sys_clk), .txn(txn_in));
  // clock and cycle ceiling
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // register write, one enabled edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    reg_req <= '0;
  endtask
  // register read, answer registered at the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    reg_req <= '0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", e, reg_rdata);
  endtask
  // decode one transaction and compare the forwarded result
  task automatic fwd(input logic [1:0] p, input logic [6:0] a, input logic w, input logic h,
                     input logic [2:0] s, input logic [6:0] pa, input logic ak);
    ria_host_model_inst.send(p, a, w);
    chk("valid", 8'h01, {7'h00, fwd_out.valid});
    chk("port", {6'h00, p}, {6'h00, fwd_out.port});
    chk("hit", {7'h00, h}, {7'h00, fwd_out.hit});
    chk("slot", {5'h00, s}, {5'h00, fwd_out.slot});
    chk("phys", {1'b0, pa}, {1'b0, fwd_out.phys_addr});
    chk("ack", {7'h00, ak}, {7'h00, fwd_out.auto_ack});
    chk("ack_wr", {7'h00, ak & w}, {7'h00, fwd_auto_ack_wr});
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(ria_pkg::ALIAS_BASE + 8'(i), 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ports();
    wr(ria_pkg::PORT_SEL_OFS, 8'h01);
    rd(ria_pkg::PORT_SEL_OFS, 8'h01);
    wr(ria_pkg::ALIAS_SLOT_FOUR, 8'ha5);
    rd(ria_pkg::ALIAS_SLOT_FOUR, 8'ha5);
    wr(ria_pkg::PORT_SEL_OFS, 8'h00);
    rd(ria_pkg::ALIAS_SLOT_FOUR, 8'h00);
    wr(8'hf0, 8'h5a);
    rd(8'hf0, 8'h00);
    @(negedge sys_clk);
    clk_en <= 1'b0;
    wr(ria_pkg::ALIAS_SLOT_FIVE, 8'h3c);
    clk_en <= 1'b1;
    rd(ria_pkg::ALIAS_SLOT_FIVE, 8'h00);
    $display("test ports done");
  endtask
  task automatic t_remap();
    wr(ria_pkg::PORT_SEL_OFS, 8'h01);
    wr(ria_pkg::PHYS_ID_BASE + 8'h04, 8'h85);
    rd(ria_pkg::PHYS_ID_BASE + 8'h04, 8'h84);
    wr(ria_pkg::PHYS_ID_BASE + 8'h06, 8'h2a);
    wr(ria_pkg::ALIAS_SLOT_FOUR, 8'h67);
    wr(ria_pkg::ALIAS_SLOT_SIX, 8'h66);
    fwd(2'h1, 7'h33, 1'b1, 1'b1, 3'h4, 7'h42, 1'b1);
    fwd(2'h1, 7'h33, 1'b0, 1'b1, 3'h4, 7'h42, 1'b1);
    fwd(2'h0, 7'h33, 1'b1, 1'b0, 3'h0, 7'h00, 1'b0);
    fwd(2'h1, 7'h00, 1'b1, 1'b0, 3'h0, 7'h00, 1'b0);
    wr(ria_pkg::ALIAS_SLOT_FOUR, 8'h00);
    fwd(2'h1, 7'h33, 1'b1, 1'b1, 3'h6, 7'h15, 1'b0);
    $display("test remap done");
  endtask
  // write then read on consecutive enabled edges
  task automatic t_b2b();
    @(negedge sys_clk);
    reg_req <= '{1'b1, 1'b0, ria_pkg::ALIAS_SLOT_FOUR, 8'h4b};
    @(negedge sys_clk);
    reg_req <= '{1'b0, 1'b1, ria_pkg::ALIAS_SLOT_FOUR, 8'h00};
    @(negedge sys_clk);
    reg_req <= '0;
    chk("b2b_alias", 8'h4b, reg_rdata);
    @(negedge sys_clk);
    reg_req <= '{1'b1, 1'b0, ria_pkg::PHYS_ID_BASE, 8'h37};
    @(negedge sys_clk);
    reg_req <= '{1'b0, 1'b1, ria_pkg::PHYS_ID_BASE, 8'h00};
    @(negedge sys_clk);
    reg_req <= '0;
    chk("b2b_phys", 8'h36, reg_rdata);
    $display("test back to back done");
  endtask
  // reset again in mid-run, all fields back to zero
  task automatic t_rerst();
    @(negedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(negedge sys_clk);
    arst_n <= 1'b1;
    rd(ria_pkg::PORT_SEL_OFS, 8'h00);
    wr(ria_pkg::PORT_SEL_OFS, 8'h01);
    rd(ria_pkg::ALIAS_SLOT_SIX, 8'h00);
    rd(ria_pkg::PHYS_ID_BASE + 8'h06, 8'h00);
    fwd(2'h1, 7'h33, 1'b1, 1'b0, 3'h0, 7'h00, 1'b0);
    $display("test mid-run reset done");
  endtask
  // reset, then scenarios
  initial begin
    arst_n = 0;
    clk_en = 1;
    reg_req = '0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1;
    t_reset();
    t_ports();
    t_b2b();
    t_remap();
    t_rerst();
    summarize();
  end
endmodule
